// ---- hdl/fault_mask_pkg.sv ----
// Purpose: constants and carriers of the fault condition mask unit
// Assumes: 24-bit condition vector, 32-bit classic Wishbone slave
// Notes:   byte offsets, one aligned word per register
package fault_mask_pkg;

  // -------------------------------------------------------------------------
  // condition vector
  // -------------------------------------------------------------------------
  localparam int          COND_W        = 24;
  localparam logic [23:0] COND_VALID    = 24'h3FFBFF;
  localparam logic [23:0] LATCH_MASK_RST = 24'h1F9B01;
  localparam logic [23:0] AMP_MASK_RST  = 24'h049801;
  localparam logic [23:0] HOST_MASK_RST = 24'h000000;
  localparam logic [7:0]  SRQ_CODE      = 8'h33;
  localparam int          BIT_ENC1_FB   = 0;
  localparam int          BIT_POS_SWLIM = 6;
  localparam int          BIT_RD_FB     = 11;
  localparam int          BIT_USR_TRAP1 = 16;
  localparam int          BIT_CAL_RANGE = 21;

  // -------------------------------------------------------------------------
  // register map and fields
  // -------------------------------------------------------------------------
  localparam logic [7:0] OFS_LATCH   = 8'h00;
  localparam logic [7:0] OFS_AMP     = 8'h04;
  localparam logic [7:0] OFS_HOST    = 8'h08;
  localparam logic [7:0] OFS_ERR     = 8'h0C;
  localparam logic [7:0] OFS_LIVE    = 8'h10;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h18;
  localparam logic [7:0] OFS_CTRL    = 8'h1C;
  localparam int         IRQ_W       = 3;
  localparam int         IRQ_LATCH   = 0;
  localparam int         IRQ_AMP     = 1;
  localparam int         IRQ_SRQ     = 2;
  localparam int         CTRL_AMP_EN = 0;

  // -------------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } srq_t;

  // byte-lane merge of write data into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ---- hdl/fault_condition_mask_unit.sv ----
// Purpose: masks fault conditions into latch, amplifier-off and host requests
// Assumes: condition pins are asynchronous; single 25 MHz clock
// Notes:   ce_i low freezes every flip-flop
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module fault_condition_mask_unit (
  // clock, reset, enable
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  // condition pins
  input  wire logic [23:0]             cond_i,
  // wishbone slave
  input  wire fault_mask_pkg::wb_req_t wb_req_i,
  output var  fault_mask_pkg::wb_rsp_t wb_rsp_o,
  // amplifier, host, interrupt
  output var  logic                    amp_enable_o,
  output var  fault_mask_pkg::srq_t    srq_o,
  output var  logic                    irq_o
);
  import fault_mask_pkg::*;

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  logic [23:0]      sync1_reg;
  logic [23:0]      sync2_reg;
  logic [23:0]      sync3_reg;
  logic [23:0]      cond_reg;
  logic [23:0]      cond_next;
  logic [23:0]      prev_reg;
  logic [23:0]      latch_reg;
  logic [23:0]      latch_next;
  logic [23:0]      amp_mask_reg;
  logic [23:0]      amp_mask_next;
  logic [23:0]      host_reg;
  logic [23:0]      host_next;
  logic [23:0]      err_reg;
  logic [23:0]      err_next;
  logic [IRQ_W-1:0] irq_st_reg;
  logic [IRQ_W-1:0] irq_st_next;
  logic [IRQ_W-1:0] irq_msk_reg;
  logic [IRQ_W-1:0] irq_msk_next;
  logic             amp_en_reg;
  logic             amp_en_next;

  // -------------------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------------------
  wire        bus_req = wb_req_i.cyc & wb_req_i.stb;
  wire        bus_acc = bus_req & ~wb_rsp_o.ack;
  // writes land at the edge where the master samples ack, request still held
  wire        bus_wr  = bus_req & wb_rsp_o.ack & wb_req_i.we;
  wire [7:0]  adr     = {wb_req_i.adr[7:2], 2'b00};
  wire        wr_latch = bus_wr & (adr == OFS_LATCH);
  wire        wr_amp   = bus_wr & (adr == OFS_AMP);
  wire        wr_host  = bus_wr & (adr == OFS_HOST);
  wire        wr_err   = bus_wr & (adr == OFS_ERR);
  wire        wr_ist   = bus_wr & (adr == OFS_IRQ_ST);
  wire        wr_imsk  = bus_wr & (adr == OFS_IRQ_MSK);
  wire        wr_ctrl  = bus_wr & (adr == OFS_CTRL);
  wire [31:0] wr_lanes = lane_merge(32'h0000_0000, wb_req_i.dat, wb_req_i.sel);

  // -------------------------------------------------------------------------
  // condition processing
  // -------------------------------------------------------------------------
  // pin order kept
  // a bit changes once the second and third stages agree
  assign cond_next = (sync2_reg & sync3_reg) | (cond_reg & (sync2_reg ^ sync3_reg));

  wire [23:0] cond_eff = cond_reg & COND_VALID;
  wire [23:0] cond_rise = cond_eff & ~prev_reg;

  wire [23:0] latch_hit = cond_eff & latch_reg;

  wire        amp_trip = |(cond_eff & amp_mask_reg);

  wire        srq_evt = |(cond_rise & host_reg);

  wire        latch_evt = |(latch_hit & ~err_reg);
  wire        amp_evt   = amp_en_reg & amp_trip;

  // -------------------------------------------------------------------------
  // next values
  // -------------------------------------------------------------------------
  // masks keep only implemented bits; merged words cut back to 24 bits
  wire [31:0] latch_wr = lane_merge({8'h00, latch_reg}, wb_req_i.dat, wb_req_i.sel);
  wire [31:0] amp_wr   = lane_merge({8'h00, amp_mask_reg}, wb_req_i.dat, wb_req_i.sel);
  wire [31:0] host_wr  = lane_merge({8'h00, host_reg}, wb_req_i.dat, wb_req_i.sel);
  assign latch_next    = wr_latch ? (latch_wr[23:0] & COND_VALID) : latch_reg;
  assign amp_mask_next = wr_amp ? (amp_wr[23:0] & COND_VALID) : amp_mask_reg;
  assign host_next     = wr_host ? (host_wr[23:0] & COND_VALID) : host_reg;

  assign err_next = (err_reg & ~(wr_err ? wr_lanes[23:0] : 24'h000000)) | latch_hit;

  // sticky events, set wins over clear
  assign irq_st_next = (irq_st_reg & ~(wr_ist ? wr_lanes[IRQ_W-1:0] : 3'h0))
                     | {srq_evt, amp_evt, latch_evt};
  wire [31:0] imsk_wr = lane_merge({29'h0, irq_msk_reg}, wb_req_i.dat, wb_req_i.sel);
  assign irq_msk_next = wr_imsk ? imsk_wr[IRQ_W-1:0] : irq_msk_reg;

  assign amp_en_next = amp_trip ? 1'b0 :
                       wr_ctrl ? wr_lanes[CTRL_AMP_EN] : amp_en_reg;

  // read mux
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    case (adr)
      OFS_LATCH:   rd_data = {8'h00, latch_reg};
      OFS_AMP:     rd_data = {8'h00, amp_mask_reg};
      OFS_HOST:    rd_data = {8'h00, host_reg};
      OFS_ERR:     rd_data = {8'h00, err_reg};
      OFS_LIVE:    rd_data = {8'h00, cond_eff};
      OFS_IRQ_ST:  rd_data = {29'h0, irq_st_reg};
      OFS_IRQ_MSK: rd_data = {29'h0, irq_msk_reg};
      OFS_CTRL:    rd_data = {31'h0, amp_en_reg};
      default:     rd_data = 32'h0000_0000;
    endcase
  end

  // -------------------------------------------------------------------------
  // flip-flops
  // -------------------------------------------------------------------------
  // pin synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 24'h000000;
      sync2_reg <= 24'h000000;
      sync3_reg <= 24'h000000;
      cond_reg  <= 24'h000000;
      prev_reg  <= 24'h000000;
    end else if (ce_i) begin
      sync1_reg <= cond_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      cond_reg  <= cond_next;
      prev_reg  <= cond_eff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_reg    <= LATCH_MASK_RST;
      amp_mask_reg <= AMP_MASK_RST;
      host_reg     <= HOST_MASK_RST;
    end else if (ce_i) begin
      latch_reg    <= latch_next;
      amp_mask_reg <= amp_mask_next;
      host_reg     <= host_next;
    end
  end

  // status, interrupt, amplifier
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_reg     <= 24'h000000;
      irq_st_reg  <= 3'h0;
      irq_msk_reg <= 3'h0;
      amp_en_reg  <= 1'b0;
      irq_o       <= 1'b0;
    end else if (ce_i) begin
      err_reg     <= err_next;
      irq_st_reg  <= irq_st_next;
      irq_msk_reg <= irq_msk_next;
      amp_en_reg  <= amp_en_next;
      irq_o       <= |(irq_st_next & irq_msk_next);
    end
  end
  assign amp_enable_o = amp_en_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      srq_o <= '{valid: 1'b0, code: SRQ_CODE};
    end else if (ce_i) begin
      srq_o <= '{valid: srq_evt, code: SRQ_CODE};
    end
  end

  // bus answer, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_rsp_o <= '{ack: 1'b0, dat: 32'h0000_0000};
    end else if (ce_i) begin
      wb_rsp_o.ack <= bus_acc;
      wb_rsp_o.dat <= bus_acc ? rd_data : 32'h0000_0000;
    end
  end

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  property p_latch_set;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && (latch_hit != 24'h000000) |=>
        ((err_reg & $past(latch_hit)) == $past(latch_hit));
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("selected active condition not latched");

  property p_latch_gate;
    @(posedge clk_i) disable iff (rst_i)
      ##1 ((err_reg & ~$past(err_reg) & ~$past(latch_reg)) == 24'h000000);
  endproperty
  a_latch_gate: assert property (p_latch_gate)
    else $error("unselected condition latched");

  property p_latch_rst;
    @(posedge clk_i) rst_i |=> (latch_reg == LATCH_MASK_RST);
  endproperty
  a_latch_rst: assert property (p_latch_rst)
    else $error("latch mask reset value wrong");

  property p_amp_off;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && amp_trip |=> !amp_enable_o;
  endproperty
  a_amp_off: assert property (p_amp_off)
    else $error("amplifier left enabled on trip");

  property p_amp_rst;
    @(posedge clk_i) rst_i |=> (amp_mask_reg == AMP_MASK_RST) && !amp_enable_o;
  endproperty
  a_amp_rst: assert property (p_amp_rst)
    else $error("amplifier mask reset value wrong");

  property p_srq;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && ((cond_rise & host_reg) != 24'h000000) |=> srq_o.valid;
  endproperty
  a_srq: assert property (p_srq)
    else $error("service request missing");

  property p_srq_code;
    @(posedge clk_i) disable iff (rst_i)
      srq_o.valid |-> (srq_o.code == SRQ_CODE) && ($past(host_reg) != 24'h000000);
  endproperty
  a_srq_code: assert property (p_srq_code)
    else $error("service request code wrong");

  property p_host_rst;
    @(posedge clk_i) rst_i ##1 !rst_i |-> (host_reg == HOST_MASK_RST) && !srq_o.valid;
  endproperty
  a_host_rst: assert property (p_host_rst)
    else $error("host mask not clear after reset");

  property p_reserved;
    @(posedge clk_i) disable iff (rst_i)
      ((latch_reg | amp_mask_reg | host_reg | err_reg) & ~COND_VALID) == 24'h000000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit took effect");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      wb_rsp_o.ack && ce_i |=> !wb_rsp_o.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && bus_acc |=> wb_rsp_o.ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("bus request not answered in one cycle");

  property p_err_sticky;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && !wr_err |=> ((err_reg & $past(err_reg)) == $past(err_reg));
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error status bit lost without a clear");

  property p_srq_gate;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && ((cond_rise & host_reg) == 24'h000000) |=> !srq_o.valid;
  endproperty
  a_srq_gate: assert property (p_srq_gate)
    else $error("service request without a selected rising condition");

  property p_amp_gate;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && amp_enable_o && !amp_trip && !wr_ctrl |=> amp_enable_o;
  endproperty
  a_amp_gate: assert property (p_amp_gate)
    else $error("amplifier dropped by an unselected condition");

  property p_irq_level;
    @(posedge clk_i) disable iff (rst_i)
      irq_o == ((irq_st_reg & irq_msk_reg) != 3'h0);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level does not follow status and mask");

endmodule
`default_nettype wire

// ---- testbench/srq_host_model.sv ----
// Purpose: host side that takes service requests from the mask unit
// Assumes: one-cycle valid pulse per request, no handshake back
// Notes:   counts requests and flags any request code other than the fixed one
`timescale 1ns/10ps
`default_nettype none
module srq_host_model (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // service request from the device
  input  wire fault_mask_pkg::srq_t srq_i,
  // observations for the bench
  output var  logic [15:0]          count_o,
  output var  logic                 bad_code_o
);
  import fault_mask_pkg::*;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o    <= 16'h0000;
      bad_code_o <= 1'b0;
    end else if (srq_i.valid === 1'b1) begin
      count_o <= count_o + 16'h0001;
      if (srq_i.code !== 8'h33) begin
        bad_code_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench of the fault condition mask unit
// Assumes: classic wishbone register access, clock enable dropped once
// Notes:   conditions are given 8 cycles to pass the synchroniser
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  import fault_mask_pkg::*;
  logic        clk_i      = 1'b0;
  logic        rst_i      = 1'b1;
  logic        ce         = 1'b1;
  logic [23:0] cond_i     = 24'h000000;
  wb_req_t     req        = '0;
  wb_rsp_t     rsp;
  srq_t        srq;
  logic        amp_en;
  logic        irq;
  logic [15:0] srq_cnt;
  logic [15:0] cnt0;
  logic        bad_code;
  logic [31:0] d;
  int          num_errors = 0;
  int          compares   = 0;

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  fault_condition_mask_unit i_fault_condition_mask_unit (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cond_i(cond_i), .wb_req_i(req),
    .wb_rsp_o(rsp), .amp_enable_o(amp_en), .srq_o(srq), .irq_o(irq));
  srq_host_model i_srq_host_model (
    .clk_i(clk_i), .rst_i(rst_i), .srq_i(srq), .count_o(srq_cnt), .bad_code_o(bad_code));

  // one classic cycle: hold until ack is sampled, then release
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 100);
    `CHK(rsp.ack, 1'b1)
    d = rsp.dat;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    wb_cycle(1'b1, a, wd);
  endtask

  task automatic chkrd(input logic [7:0] a, input logic [31:0] e);
    wb_cycle(1'b0, a, 32'h00000000);
    `CHK(d, e)
  endtask

  task automatic print_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog against a hung bus
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    print_verdict();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    chkrd(OFS_LATCH, 32'h001F9B01);
    chkrd(OFS_AMP, 32'h00049801);
    chkrd(OFS_HOST, 32'h00000000);
    wr(OFS_LATCH, 32'hFFFFFFFF);
    chkrd(OFS_LATCH, 32'h003FFBFF);
    wr(OFS_AMP, 32'hFFFFFFFF);
    wr(OFS_HOST, 32'hFFFFFFFF);
    // walk one condition at a time through all three masks
    for (int i = 0; i < 24; i++) begin
      wr(OFS_CTRL, 32'h00000001);
      @(posedge clk_i);
      `CHK(amp_en, 1'b1)
      cnt0 = srq_cnt;
      cond_i <= 24'h000001 << i;
      repeat (8) @(posedge clk_i);
      `CHK(amp_en, ~COND_VALID[i])
      `CHK(srq_cnt, cnt0 + {15'h0000, COND_VALID[i]})
      chkrd(OFS_ERR, {8'h00, COND_VALID & (24'h000001 << i)});
      cond_i <= 24'h000000;
      repeat (8) @(posedge clk_i);
      wr(OFS_ERR, 32'h00FFFFFF);
    end
    // cleared masks keep every active condition out
    wr(OFS_LATCH, 32'h00000000);
    wr(OFS_AMP, 32'h00000000);
    wr(OFS_HOST, 32'h00000000);
    wr(OFS_CTRL, 32'h00000001);
    wr(OFS_IRQ_ST, 32'h00000007);
    cnt0 = srq_cnt;
    cond_i <= 24'h3FFBFF;
    repeat (8) @(posedge clk_i);
    chkrd(OFS_ERR, 32'h00000000);
    chkrd(OFS_LIVE, 32'h003FFBFF);
    chkrd(OFS_CTRL, 32'h00000001);
    `CHK(amp_en, 1'b1)
    `CHK(srq_cnt, cnt0)
    // opening one latch bit captures the still-active condition
    wr(OFS_LATCH, 32'h00000008);
    repeat (4) @(posedge clk_i);
    chkrd(OFS_ERR, 32'h00000008);
    chkrd(OFS_IRQ_ST, 32'h00000001);
    // interrupt raised, masked, unmasked and cleared
    wr(OFS_IRQ_MSK, 32'h00000001);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_MSK, 32'h00000000);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    wr(OFS_IRQ_MSK, 32'h00000001);
    cond_i <= 24'h000000;
    repeat (8) @(posedge clk_i);
    wr(OFS_IRQ_ST, 32'h00000007);
    wr(OFS_ERR, 32'h00FFFFFF);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    chkrd(8'h20, 32'h00000000);
    `CHK(bad_code, 1'b0)
    // a second reset brings back every mask default
    wr(OFS_HOST, 32'h00000080);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chkrd(OFS_LATCH, 32'h001F9B01);
    chkrd(OFS_HOST, 32'h00000000);
    chkrd(OFS_AMP, 32'h00049801);
    `CHK(amp_en, 1'b0)
    // a frozen clock enable holds off the default amplifier trip
    wr(OFS_CTRL, 32'h00000001);
    ce <= 1'b0;
    cond_i <= 24'h000001;
    repeat (8) @(posedge clk_i);
    `CHK(amp_en, 1'b1)
    ce <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK(amp_en, 1'b0)
    chkrd(OFS_ERR, 32'h00000001);
    print_verdict();
  end
endmodule
`default_nettype wire
